/* File: rtl/vcr_pkg.sv */
// Constants for the version and capability responder.
// Assumes a 32-bit AHB-Lite register bus and one core clock.
package vcr_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h04;
   localparam logic [7:0] VERSION_OFF = 8'h08;
   localparam logic [7:0] SECOND_ALPHA_CHAR_OFF = 8'h0C;
   localparam logic [7:0] NAME0_OFF = 8'h10;
   localparam logic [7:0] NAME1_OFF = 8'h14;
   localparam logic [7:0] NAME2_OFF = 8'h18;
   localparam logic [7:0] NAME_LEN_OFF = 8'h1C;
   localparam logic [7:0] FW_VER_OFF = 8'h20;
   localparam logic [7:0] MFR_OFF = 8'h24;
   localparam logic [7:0] PF_INDEX_OFF = 8'h28;
   localparam logic [7:0] PF_ID_HI_OFF = 8'h2C;
   localparam logic [7:0] PF_ID_LO_OFF = 8'h30;
   localparam logic [7:0] PF_ENABLE_OFF = 8'h34;
   localparam logic [7:0] CAP_FLAGS_OFF = 8'h38;
   localparam logic [7:0] BCAST_CAP_OFF = 8'h3C;
   localparam logic [7:0] MCAST_CAP_OFF = 8'h40;
   localparam logic [7:0] BUF_CAP_OFF = 8'h44;
   localparam logic [7:0] ALERT_CAP_OFF = 8'h48;
   localparam logic [7:0] FCOUNT_OFF = 8'h4C;
   localparam logic [7:0] VLAN_CHAN_OFF = 8'h50;
   // Control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_HOST_BUS = 1;
   localparam int CTRL_MFR_UNUSED = 2;
   localparam int CTRL_UPDATE_ABSENT = 3;
   localparam logic [3:0] CTRL_RST = 4'hD;
   // Command and response codes
   localparam logic [7:0] VER_CMD = 8'h15;
   localparam logic [7:0] CAP_CMD = 8'h16;
   localparam logic [7:0] VER_RESP = 8'h95;
   localparam logic [7:0] CAP_RESP = 8'h96;
   localparam logic [15:0] GENERIC_OK = 16'h0000;
   // Payload lengths from byte 16 up to the checksum
   localparam logic [5:0] VER_LEN = 6'h28;
   localparam logic [5:0] CAP_LEN = 6'h20;
   // Encoding constants
   localparam logic [3:0] NIBBLE_IGNORE = 4'hF;
   localparam logic [7:0] FIELD_ABSENT = 8'hFF;
   localparam logic [6:0] BCD_MAX = 7'h63;
   localparam logic [31:0] MFR_NONE = 32'hFFFFFFFF;
   localparam logic [31:0] CAP_FLAGS_MASK = 32'h0000007F;
   localparam logic [7:0] VLAN_MODE_MASK = 8'h07;
   localparam logic [7:0] VLAN_ONLY = 8'h01;
   localparam logic [7:0] VLAN_MAX = 8'h0F;
   localparam logic [9:0] FILTER_MAX = 10'h008;
   localparam logic [7:0] UCAST_FALLBACK = 8'h01;
   localparam logic [3:0] NAME_FULL = 4'hC;
endpackage

/* File: rtl/vcr_ahb_slave.sv */
// AHB-Lite slave front end for the responder registers.
// Assumes single word transfers; writes take one data cycle, reads two.
module vcr_ahb_slave (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   output logic wr_en,
   output logic [7:0] reg_addr,
   input wire logic [31:0] rd_data
);
   typedef struct packed {
      logic hreadyout;
      logic [31:0] hrdata;
      logic hresp;
      logic wr;
      logic rd;
      logic hit;
      logic [7:0] addr;
   } vcr_ahb_s;

   vcr_ahb_s s;
   vcr_ahb_s next_s;

   always_comb begin
      next_s = s;
      next_s.wr = 1'b0;
      next_s.hresp = 1'b0;
      if (s.rd) begin
         // Unmapped reads answer zero
         next_s.hrdata = s.hit ? rd_data : 32'h00000000;
         next_s.hreadyout = 1'b1;
         next_s.rd = 1'b0;
      end
      if (hready && hsel && htrans[1]) begin
         next_s.addr = haddr[7:0];
         next_s.hit = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
         next_s.wr = hwrite;
         if (!hwrite) begin
            next_s.rd = 1'b1;
            next_s.hreadyout = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.hreadyout <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout = s.hreadyout;
   assign hrdata = s.hrdata;
   assign hresp = s.hresp;
   assign wr_en = s.wr && s.hit;
   assign reg_addr = s.addr;
endmodule

/* File: rtl/vcr_responder.sv */
// Builds version and capability query responses as a byte stream.
// Assumes header and checksum are added downstream; AHB-Lite registers.
// Behaviour
// R1 - Answer version query with type 0x95
// R2 - Version bytes 20-23, second alpha at 27
// R3 - Name bytes 28-39, firmware version 40-43
// R4 - Host ids 44-51, maker 52-55, checksum 56-59
// R5 - Report identifiers of lowest enabled function
// R6 - Version bytes are packed two-digit BCD
// R7 - Alpha bytes Latin-1, first filled first
// R8 - Single digit gets upper nibble 0xF
// R9 - Update 0xFF means absent; never major/minor
// R10 - Name left-justified, first char most significant
// R11 - Short name ends with 0x00 terminator
// R12 - Firmware version is one 32-bit field
// R13 - No shared host bus gives zero ids
// R14 - Partitions use lowest assigned function ids
// R15 - Maker number 32-bit, all ones unused
// R16 - Capability query is header, checksum, padding
// R17 - Answer capability query with type 0x96
// R18 - Capability words at bytes 20 through 39
// R19 - Filter counts 40-43, VLAN modes 44-47
// R20 - Only generic reason codes returned
// R21 - Capability flag bits 0 to 6 defined
// R22 - At most 8 filters, one unicast
// R23 - VLAN filter count at most 15
// R24 - Multi-byte fields sent most significant first
//
// Added by the designer: the register addresses and the AHB-Lite slave port.
module vcr_responder #(
   parameter int FUNCS = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_error,
   output logic cmd_ready,
   input wire logic resp_ready,
   output logic resp_valid,
   output logic [7:0] resp_data,
   output logic resp_last,
   output logic [7:0] resp_type
);
   typedef enum logic {VCR_IDLE = 1'b0, VCR_SEND = 1'b1} vcr_state_e;

   typedef struct packed {
      vcr_state_e fsm;
      logic [319:0] shreg;
      logic [5:0] left;
      logic resp_valid;
      logic resp_last;
      logic [7:0] resp_type;
      logic cmd_ready;
      logic [3:0] ctrl;
      logic [31:0] version;
      logic [7:0] second_alpha_char;
      logic [95:0] name;
      logic [3:0] name_len;
      logic [31:0] fw_ver;
      logic [31:0] mfr;
      logic [2:0] pf_index;
      logic [FUNCS-1:0] pf_enable;
      logic [FUNCS-1:0][63:0] pf_id;
      logic [31:0] cap_flags;
      logic [31:0] bcast_cap;
      logic [31:0] mcast_cap;
      logic [31:0] buf_cap;
      logic [31:0] alert_cap;
      logic [31:0] fcount;
      logic [15:0] vlan_chan;
      logic [7:0] ver_cnt;
      logic [7:0] cap_cnt;
   } vcr_st_s;

   vcr_st_s s;
   vcr_st_s next_s;
   logic wr_en;
   logic [7:0] reg_addr;
   logic [31:0] rd_data;

   // Two-digit BCD with ignored upper nibble for one digit
   function automatic logic [7:0] vcr_bcd(input logic [6:0] v);
      logic [6:0] c;
      logic [3:0] tens;
      logic [3:0] ones;
      c = (v > vcr_pkg::BCD_MAX) ? vcr_pkg::BCD_MAX : v;
      tens = 4'(c / 7'd10);
      ones = 4'(c % 7'd10);
      vcr_bcd = (tens == 4'h0) ? {vcr_pkg::NIBBLE_IGNORE, ones} : {tens, ones}; // [R6] [R8]
   endfunction

   // Lowest enabled function, function 0 when none is enabled
   function automatic logic [2:0] vcr_lowest(input logic [FUNCS-1:0] m);
      vcr_lowest = 3'h0;
      for (int i = FUNCS - 1; i >= 0; i--) begin
         if (m[i]) begin
            vcr_lowest = 3'(i);
         end
      end
   endfunction

   vcr_ahb_slave u_slave (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .wr_en(wr_en),
      .reg_addr(reg_addr),
      .rd_data(rd_data)
   );

   // Response images
   logic [7:0] ver_major;
   logic [7:0] ver_minor;
   logic [7:0] ver_update;
   logic [7:0] alpha_a;
   logic [7:0] alpha_b;
   logic [95:0] name_out;
   logic [63:0] ids;
   logic [31:0] mfr_out;
   logic [9:0] fsum;
   logic fault;
   logic [31:0] counts;
   logic [7:0] vlan_mode;
   logic [319:0] ver_img;
   logic [319:0] cap_img;

   always_comb begin
      ver_major = vcr_bcd(s.version[6:0]); // [R9]
      ver_minor = vcr_bcd(s.version[14:8]); // [R9]
      ver_update = s.ctrl[vcr_pkg::CTRL_UPDATE_ABSENT] ? vcr_pkg::FIELD_ABSENT
                   : vcr_bcd(s.version[22:16]); // [R9]
      // Second alpha moves up when the first is empty
      alpha_a = (s.version[31:24] != 8'h00) ? s.version[31:24] : s.second_alpha_char; // [R7]
      alpha_b = (s.version[31:24] != 8'h00) ? s.second_alpha_char : 8'h00; // [R7]
      for (int k = 0; k < 12; k++) begin
         // First character in the top byte, zero from the length on
         name_out[95 - 8*k -: 8] = (4'(k) < s.name_len) ? s.name[95 - 8*k -: 8]
                                   : 8'h00; // [R10] [R11]
      end
      ids = s.ctrl[vcr_pkg::CTRL_HOST_BUS] ? s.pf_id[vcr_lowest(s.pf_enable)]
            : 64'h0; // [R5] [R13] [R14]
      mfr_out = s.ctrl[vcr_pkg::CTRL_MFR_UNUSED] ? vcr_pkg::MFR_NONE : s.mfr; // [R15]
      fsum = 10'(s.fcount[23:16]) + 10'(s.fcount[15:8]) + 10'(s.fcount[7:0]);
      fault = (fsum > vcr_pkg::FILTER_MAX)
              || ((s.fcount[23:16] == 8'h00) && (s.fcount[7:0] == 8'h00)); // [R22]
      counts[31:24] = (s.fcount[31:24] > vcr_pkg::VLAN_MAX) ? vcr_pkg::VLAN_MAX
                      : s.fcount[31:24]; // [R23]
      counts[23:0] = fault ? {16'h0000, vcr_pkg::UCAST_FALLBACK} : s.fcount[23:0]; // [R22]
      vlan_mode = (s.vlan_chan[15:8] & vcr_pkg::VLAN_MODE_MASK) | vcr_pkg::VLAN_ONLY;
      // Bytes 16 upward, most significant first
      ver_img = {vcr_pkg::GENERIC_OK, vcr_pkg::GENERIC_OK, // [R20]
                 ver_major, ver_minor, ver_update, alpha_a, // [R2]
                 24'h000000, alpha_b, // [R2]
                 name_out, s.fw_ver, // [R3] [R12]
                 ids, mfr_out}; // [R4] [R24]
      cap_img = {vcr_pkg::GENERIC_OK, vcr_pkg::GENERIC_OK, // [R20]
                 s.cap_flags & vcr_pkg::CAP_FLAGS_MASK, // [R21]
                 s.bcast_cap, s.mcast_cap, s.buf_cap, s.alert_cap, // [R18]
                 counts, 16'h0000, vlan_mode, s.vlan_chan[7:0], // [R19]
                 64'h0}; // [R24]
   end

   // Register reads
   always_comb begin
      case (reg_addr)
         vcr_pkg::CTRL_OFF: rd_data = {28'h0, s.ctrl};
         vcr_pkg::STATUS_OFF: rd_data = {8'h00, s.cap_cnt, s.ver_cnt, 6'h00, fault,
                                         s.fsm == VCR_SEND};
         vcr_pkg::VERSION_OFF: rd_data = s.version;
         vcr_pkg::SECOND_ALPHA_CHAR_OFF: rd_data = {24'h0, s.second_alpha_char};
         vcr_pkg::NAME0_OFF: rd_data = s.name[95:64];
         vcr_pkg::NAME1_OFF: rd_data = s.name[63:32];
         vcr_pkg::NAME2_OFF: rd_data = s.name[31:0];
         vcr_pkg::NAME_LEN_OFF: rd_data = {28'h0, s.name_len};
         vcr_pkg::FW_VER_OFF: rd_data = s.fw_ver;
         vcr_pkg::MFR_OFF: rd_data = s.mfr;
         vcr_pkg::PF_INDEX_OFF: rd_data = {29'h0, s.pf_index};
         vcr_pkg::PF_ID_HI_OFF: rd_data = s.pf_id[s.pf_index][63:32];
         vcr_pkg::PF_ID_LO_OFF: rd_data = s.pf_id[s.pf_index][31:0];
         vcr_pkg::PF_ENABLE_OFF: rd_data = 32'(s.pf_enable);
         vcr_pkg::CAP_FLAGS_OFF: rd_data = s.cap_flags;
         vcr_pkg::BCAST_CAP_OFF: rd_data = s.bcast_cap;
         vcr_pkg::MCAST_CAP_OFF: rd_data = s.mcast_cap;
         vcr_pkg::BUF_CAP_OFF: rd_data = s.buf_cap;
         vcr_pkg::ALERT_CAP_OFF: rd_data = s.alert_cap;
         vcr_pkg::FCOUNT_OFF: rd_data = s.fcount;
         vcr_pkg::VLAN_CHAN_OFF: rd_data = {16'h0000, s.vlan_chan};
         default: rd_data = 32'h00000000;
      endcase
   end

   always_comb begin
      next_s = s;
      // Register writes
      if (wr_en) begin
         case (reg_addr)
            vcr_pkg::CTRL_OFF: next_s.ctrl = hwdata[3:0];
            vcr_pkg::VERSION_OFF: next_s.version = hwdata;
            vcr_pkg::SECOND_ALPHA_CHAR_OFF: next_s.second_alpha_char = hwdata[7:0];
            vcr_pkg::NAME0_OFF: next_s.name[95:64] = hwdata;
            vcr_pkg::NAME1_OFF: next_s.name[63:32] = hwdata;
            vcr_pkg::NAME2_OFF: next_s.name[31:0] = hwdata;
            vcr_pkg::NAME_LEN_OFF: next_s.name_len = (hwdata[3:0] > vcr_pkg::NAME_FULL)
                                                     ? vcr_pkg::NAME_FULL : hwdata[3:0];
            vcr_pkg::FW_VER_OFF: next_s.fw_ver = hwdata;
            vcr_pkg::MFR_OFF: next_s.mfr = hwdata;
            vcr_pkg::PF_INDEX_OFF: next_s.pf_index = hwdata[2:0];
            vcr_pkg::PF_ID_HI_OFF: next_s.pf_id[s.pf_index][63:32] = hwdata;
            vcr_pkg::PF_ID_LO_OFF: next_s.pf_id[s.pf_index][31:0] = hwdata;
            vcr_pkg::PF_ENABLE_OFF: next_s.pf_enable = hwdata[FUNCS-1:0];
            vcr_pkg::CAP_FLAGS_OFF: next_s.cap_flags = hwdata;
            vcr_pkg::BCAST_CAP_OFF: next_s.bcast_cap = hwdata;
            vcr_pkg::MCAST_CAP_OFF: next_s.mcast_cap = hwdata;
            vcr_pkg::BUF_CAP_OFF: next_s.buf_cap = hwdata;
            vcr_pkg::ALERT_CAP_OFF: next_s.alert_cap = hwdata;
            vcr_pkg::FCOUNT_OFF: next_s.fcount = hwdata;
            vcr_pkg::VLAN_CHAN_OFF: next_s.vlan_chan = hwdata[15:0];
            default: next_s.ctrl = s.ctrl;
         endcase
      end
      // Response sequencer
      case (s.fsm)
         VCR_IDLE: begin
            if (cmd_valid && !cmd_error && s.ctrl[vcr_pkg::CTRL_ENABLE]) begin
               if (cmd_code == vcr_pkg::VER_CMD) begin
                  next_s.shreg = ver_img;
                  next_s.left = vcr_pkg::VER_LEN;
                  next_s.resp_type = vcr_pkg::VER_RESP; // [R1]
                  next_s.ver_cnt = s.ver_cnt + 8'h01;
                  next_s.resp_valid = 1'b1;
                  next_s.fsm = VCR_SEND;
               end else if (cmd_code == vcr_pkg::CAP_CMD) begin // [R16]
                  next_s.shreg = cap_img;
                  next_s.left = vcr_pkg::CAP_LEN;
                  next_s.resp_type = vcr_pkg::CAP_RESP; // [R17]
                  next_s.cap_cnt = s.cap_cnt + 8'h01;
                  next_s.resp_valid = 1'b1;
                  next_s.fsm = VCR_SEND;
               end
            end
         end
         VCR_SEND: begin
            if (resp_ready) begin
               if (s.left == 6'h01) begin
                  next_s.resp_valid = 1'b0;
                  next_s.resp_last = 1'b0;
                  next_s.fsm = VCR_IDLE;
               end else begin
                  next_s.shreg = {s.shreg[311:0], 8'h00}; // [R24]
                  next_s.left = s.left - 6'h01;
                  next_s.resp_last = (s.left == 6'h02);
               end
            end
         end
         default: next_s.fsm = VCR_IDLE;
      endcase
      next_s.cmd_ready = (next_s.fsm == VCR_IDLE);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.ctrl <= vcr_pkg::CTRL_RST;
         s.cmd_ready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign cmd_ready = s.cmd_ready;
   assign resp_valid = s.resp_valid;
   assign resp_data = s.shreg[319:312];
   assign resp_last = s.resp_last;
   assign resp_type = s.resp_type;
endmodule

/* File: tb/vcr_sva.sv */
// Checker for the responder command and byte stream ports.
// Assumes binding to vcr_responder; one clock, async active-low reset.
module vcr_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic cmd_error,
   input wire logic cmd_ready,
   input wire logic resp_ready,
   input wire logic resp_valid,
   input wire logic [7:0] resp_data,
   input wire logic resp_last,
   input wire logic [7:0] resp_type
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [5:0] cnt;
   logic take;
   logic acc;
   assign take = cmd_valid && cmd_ready && !cmd_error;
   assign acc = resp_valid && resp_ready;
   // Index of the byte in flight, counted from payload byte 16
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 6'h00;
      end else if (acc) begin
         cnt <= resp_last ? 6'h00 : cnt + 6'h01;
      end
   end
   a_ver_type: assert property (
      take && cmd_code == 8'h15 ##1 resp_valid |-> resp_type == 8'h95)
      else $error("version response type wrong");
   a_cap_type: assert property (
      take && cmd_code == 8'h16 ##1 resp_valid |-> resp_type == 8'h96)
      else $error("capability response type wrong");
   a_err_drop: assert property (
      cmd_valid && cmd_ready && cmd_error |=> !resp_valid)
      else $error("command in error answered");
   a_reason_zero: assert property (
      $rose(resp_valid) |-> resp_data == 8'h00)
      else $error("response code not generic");
   a_byte_hold: assert property (
      resp_valid && !resp_ready |=> resp_valid && $stable(resp_data))
      else $error("byte changed while stalled");
   a_ver_len: assert property (
      acc && resp_last && resp_type == 8'h95 |-> cnt == 6'h27)
      else $error("version response length wrong");
   a_cap_len: assert property (
      acc && resp_last && resp_type == 8'h96 |-> cnt == 6'h1F)
      else $error("capability response length wrong");
   a_major_minor: assert property (
      acc && resp_type == 8'h95 && cnt inside {6'h04, 6'h05} |-> resp_data != 8'hFF)
      else $error("major or minor is 0xFF");
   a_vlan_max: assert property (
      acc && resp_type == 8'h96 && cnt == 6'h18 |-> resp_data <= 8'h0F)
      else $error("vlan filter count above 15");
   a_flag_rsv: assert property (
      acc && resp_type == 8'h96 && cnt inside {[6'h04:6'h06]} |-> resp_data == 8'h00)
      else $error("reserved flag bits set");
   c_ver_done: cover property (acc && resp_last && resp_type == 8'h95);
   c_cap_done: cover property (acc && resp_last && resp_type == 8'h96);
   c_stall: cover property (resp_valid && !resp_ready);
endmodule

bind vcr_responder vcr_sva chk_u (.hclk(hclk), .hresetn(hresetn), .cmd_valid(cmd_valid),
   .cmd_code(cmd_code), .cmd_error(cmd_error), .cmd_ready(cmd_ready),
   .resp_ready(resp_ready), .resp_valid(resp_valid), .resp_data(resp_data),
   .resp_last(resp_last), .resp_type(resp_type));

/* File: tb/vcr_mc_model.sv */
// Management controller model: issues queries, sinks response bytes.
// Assumes the responder command and response ports, one clock.
module vcr_mc_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   output logic cmd_error,
   input wire logic cmd_ready,
   output logic resp_ready,
   input wire logic resp_valid,
   input wire logic [7:0] resp_data,
   input wire logic resp_last
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   int last_at;
   logic hung;
   initial begin
      hung = 1'b0;
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_error = 1'b0;
      resp_ready = 1'b0;
      last_at = 0;
   end
   // Sink accepts promptly, or stalls at random when slow
   always @(posedge hclk) begin
      resp_ready <= !slow || ($urandom_range(0, 2) == 0);
      if (hresetn && resp_valid && resp_ready) begin
         got.push_back(resp_data);
         if (resp_last) last_at = got.size();
      end
   end
   // Query held until taken or for at most 50 cycles; code line scrambled once released
   task automatic issue(input logic [7:0] code, input logic err);
      logic taken;
      taken = 1'b0;
      cmd_code <= code;
      cmd_error <= err;
      cmd_valid <= 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge hclk);
         if (cmd_ready === 1'b1) begin
            taken = 1'b1;
            break;
         end
      end
      // Query never taken: flagged for the bench's timeout report
      if (!taken) hung = 1'b1;
      cmd_valid <= 1'b0;
      cmd_code <= ~code;
   endtask
endmodule

/* File: tb/vcr_responder_tb_top.sv */
// Testbench for the version and capability responder.
// Assumes vcr_responder, vcr_mc_model and the bound checker.
module vcr_responder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, slow;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [7:0] cmd_code, resp_data, resp_type;
   logic cmd_valid, cmd_error, cmd_ready, resp_ready, resp_valid, resp_last;
   logic [7:0] exp[64];
   logic [31:0] r[64];
   logic [31:0] hi[8];
   logic [31:0] lo[8];
   int error_cnt;
   int compares;
   vcr_responder dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_error(cmd_error), .cmd_ready(cmd_ready),
      .resp_ready(resp_ready), .resp_valid(resp_valid), .resp_data(resp_data),
      .resp_last(resp_last), .resp_type(resp_type));
   vcr_mc_model model_u (.hclk(hclk), .hresetn(hresetn), .slow(slow),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_error(cmd_error),
      .cmd_ready(cmd_ready), .resp_ready(resp_ready), .resp_valid(resp_valid),
      .resp_data(resp_data), .resp_last(resp_last));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   task automatic summarize();
      $display("Errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         error_cnt++;
         $display("Error at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1) begin
         n++;
         if (n > 20) begin
            error_cnt++;
            summarize();
         end
         @(posedge hclk);
      end
   endtask
   // One AHB-Lite single word transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
      if (w) r[a[7:2]] = d;
   endtask
   function automatic logic [7:0] bcd(input logic [7:0] v);
      logic [7:0] x;
      x = (v > 8'h63) ? 8'h63 : v;
      return (x < 8'h0A) ? {4'hF, x[3:0]} : {4'(x / 8'h0A), 4'(x % 8'h0A)};
   endfunction
   function automatic void put(input int at, input logic [31:0] v);
      for (int i = 0; i < 4; i++) exp[at + i] = 8'(v >> (24 - 8 * i));
   endfunction
   function automatic void build_ver();
      logic [31:0] v;
      logic [3:0] len;
      int f;
      v = r[2];
      len = (r[7][3:0] > 4'hC) ? 4'hC : r[7][3:0];
      f = 0;
      for (int i = 7; i >= 0; i--) if (r[13][i]) f = i;
      for (int i = 0; i < 64; i++) exp[i] = 8'h00;
      exp[20] = bcd({1'b0, v[6:0]});
      exp[21] = bcd({1'b0, v[14:8]});
      exp[22] = r[0][3] ? 8'hFF : bcd({1'b0, v[22:16]});
      exp[23] = (v[31:24] != 8'h00) ? v[31:24] : r[3][7:0];
      exp[27] = (v[31:24] != 8'h00) ? r[3][7:0] : 8'h00;
      for (int i = 0; i < 12; i++) exp[28 + i] = (i < len) ? 8'(r[4 + i / 4] >> (24 - 8 * (i % 4))) : 8'h00;
      put(40, r[8]);
      put(44, r[0][1] ? hi[f] : 32'h0);
      put(48, r[0][1] ? lo[f] : 32'h0);
      put(52, r[0][2] ? 32'hFFFFFFFF : r[9]);
   endfunction
   function automatic void build_cap();
      logic [7:0] u, m, x;
      u = r[19][7:0];
      m = r[19][15:8];
      x = r[19][23:16];
      for (int i = 0; i < 64; i++) exp[i] = 8'h00;
      put(20, r[14] & 32'h0000007F);
      for (int i = 0; i < 4; i++) put(24 + 4 * i, r[15 + i]);
      exp[40] = (r[19][31:24] > 8'h0F) ? 8'h0F : r[19][31:24];
      if (10'(u) + 10'(m) + 10'(x) > 10'h008 || 10'(u) + 10'(x) == 10'h000) begin
         u = 8'h01;
         m = 8'h00;
         x = 8'h00;
      end
      exp[41] = x;
      exp[42] = m;
      exp[43] = u;
      exp[46] = (r[20][15:8] & 8'h07) | 8'h01;
      exp[47] = r[20][7:0];
   endfunction
   // Issue a query, collect n bytes and compare against exp from byte 16
   task automatic run(input logic [7:0] code, input int n);
      model_u.got.delete();
      model_u.issue(code, 1'b0);
      for (int t = 0; t < 400 && model_u.got.size() < n; t++) @(posedge hclk);
      if (model_u.hung || model_u.got.size() < n) begin
         error_cnt++;
         summarize();
      end
      repeat (2) @(posedge hclk);
      check(model_u.got.size(), n);
      check(model_u.last_at, n);
      check(cmd_ready, 1'b1);
      check(resp_type, code | 8'h80);
      for (int i = 0; i < n; i++) check(model_u.got[i], exp[16 + i]);
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      slow = 1'b0;
      error_cnt = 0;
      compares = 0;
      void'($urandom(78));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check({resp_valid, cmd_ready, hresp}, 32'h2);
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'hD);
      bus(1'b0, 8'h80, 32'h0);
      check(rd, 32'h0);
      for (int k = 0; k < 6; k++) begin
         slow <= k[0];
         for (int j = 0; j < 8; j++) begin
            bus(1'b1, 8'h28, j);
            bus(1'b1, 8'h2C, $urandom);
            hi[j] = r[11];
            bus(1'b1, 8'h30, $urandom);
            lo[j] = r[12];
         end
         for (int i = 2; i < 21; i++) if (i < 10 || i > 12) bus(1'b1, 8'(i * 4), $urandom);
         bus(1'b1, 8'h34, {24'h0, 8'($urandom)});
         bus(1'b1, 8'h00, {28'h0, 3'($urandom), 1'b1});
         if (k == 0) begin
            bus(1'b1, 8'h00, 32'hD);
            bus(1'b1, 8'h1C, 32'hC);
            bus(1'b1, 8'h4C, 32'h10050403);
            bus(1'b1, 8'h08, 32'h00FF0A05);
         end
         if (k == 1) begin
            bus(1'b1, 8'h1C, 32'h0);
            bus(1'b1, 8'h4C, 32'h0F000300);
            bus(1'b1, 8'h34, 32'h0);
            bus(1'b1, 8'h08, 32'h00630909);
         end
         build_ver();
         run(8'h15, 40);
         build_cap();
         run(8'h16, 32);
      end
      for (int k = 0; k < 5; k++) begin
         // Errored, unknown, then disabled queries: none is answered
         if (k == 3) bus(1'b1, 8'h00, 32'h0);
         model_u.got.delete();
         model_u.issue((k == 2) ? 8'h17 : (k[0] ? 8'h16 : 8'h15), k < 2);
         if (model_u.hung) begin
            error_cnt++;
            summarize();
         end
         repeat (4) @(posedge hclk);
         check(model_u.got.size(), 0);
         check(resp_valid, 1'b0);
      end
      summarize();
   end
endmodule
